// >>> core/byte_add_carry_unit_consts.vh
`ifndef BYTE_ADD_CARRY_UNIT_CONSTS_VH
`define BYTE_ADD_CARRY_UNIT_CONSTS_VH

// Opcodes, carry-add
`define OPC_ADC_RR      8'h12
`define OPC_ADC_R_IR    8'h13
`define OPC_ADC_REG     8'h14
`define OPC_ADC_IREG    8'h15
`define OPC_ADC_IMM     8'h16
// Opcodes, plain add
`define OPC_ADD_RR      8'h02
`define OPC_ADD_R_IR    8'h03
`define OPC_ADD_REG     8'h04
`define OPC_ADD_IREG    8'h05
`define OPC_ADD_IMM     8'h06

// Instruction lengths and cycle counts
`define LEN_SHORT       2'd2
`define LEN_LONG        2'd3
`define CYC_SHORT       3'd4
`define CYC_LONG        3'd6

// Flag positions in flag vectors
`define FLG_C           0
`define FLG_Z           1
`define FLG_S           2
`define FLG_V           3
`define FLG_D           4
`define FLG_H           5

// Addressing mode codes
`define MODE_WORK       3'h0
`define MODE_IND_WORK   3'h1
`define MODE_REG        3'h2
`define MODE_IND_FULL   3'h3
`define MODE_IMM        3'h4

// Reset values
`define RST_BYTE        8'h00
`define RST_FLAGS       6'h00

`endif

// >>> core/add_result_stage.v
`timescale 1ns/1ps
`include "byte_add_carry_unit_consts.vh"

// Holds result and flags, loads them together
module add_result_stage (
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Load side
    input  wire       load,
    input  wire [7:0] next_result,
    input  wire [5:0] next_flags,
    // Held values
    output reg  [7:0] result,
    output reg  [5:0] flags
);

    always @(posedge clk) begin
        if (!rstn) begin
            result <= `RST_BYTE;
            flags  <= `RST_FLAGS;
        end else if (load) begin
            result <= next_result;
            flags  <= next_flags;
        end
    end

endmodule // add_result_stage

// >>> core/byte_add_carry_unit.v
//
// Contract
// - Carry-add sums dst, src and carry
// - Plain add sums dst and src only
// - Source operand is never written
// - Incoming carry chains multi-byte additions
// - Carry set on carry out of bit7
// - Zero set when result equals zero
// - Sign set when result bit7 is one
// - Overflow on same-sign inputs, opposite result
// - Decimal-adjust flag always cleared
// - Half-carry set on carry out of bit3
// - Carry-add opcodes 12..16 with lengths, cycles
// - Plain-add opcodes 02..06 with lengths, cycles
// - Long forms order operand bytes per mode
`timescale 1ns/1ps
`include "byte_add_carry_unit_consts.vh"

module byte_add_carry_unit (
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Instruction from sequencer
    input  wire       start,
    input  wire [7:0] opcode,
    input  wire [7:0] operand1,
    input  wire [7:0] operand2,
    // Operand values from register file
    input  wire [7:0] dst_value,
    input  wire [7:0] src_value,
    input  wire       carry_in,
    // Decode outputs
    output reg        decode_valid,
    output reg        decode_illegal,
    output reg        with_carry,
    output reg  [2:0] src_mode,
    output reg  [2:0] dst_mode,
    output reg  [1:0] instr_bytes,
    output reg  [2:0] instr_cycles,
    output reg  [7:0] dst_addr,
    output reg  [7:0] src_addr,
    output reg  [7:0] imm_value,
    // Results
    output reg        busy,
    output reg        done,
    output reg        dst_write,
    output reg  [7:0] dst_write_addr,
    output wire [7:0] result,
    output wire       flag_c,
    output wire       flag_z,
    output wire       flag_s,
    output wire       flag_v,
    output wire       flag_d,
    output wire       flag_h
);

    // Decode helpers
    function is_add_op;
        input [7:0] op;
        begin
            is_add_op = (op >= `OPC_ADD_RR && op <= `OPC_ADD_IMM) ||
                        (op >= `OPC_ADC_RR && op <= `OPC_ADC_IMM);
        end
    endfunction

    function [2:0] src_mode_of;
        input [7:0] op;
        begin
            case (op[3:0])
                4'h2:    src_mode_of = `MODE_WORK;
                4'h3:    src_mode_of = `MODE_IND_WORK;
                4'h4:    src_mode_of = `MODE_REG;
                4'h5:    src_mode_of = `MODE_IND_FULL;
                4'h6:    src_mode_of = `MODE_IMM;
                default: src_mode_of = `MODE_WORK;
            endcase
        end
    endfunction

    function is_long_mode;
        input [2:0] mode;
        begin
            is_long_mode = (mode == `MODE_REG) || (mode == `MODE_IND_FULL) ||
                           (mode == `MODE_IMM);
        end
    endfunction

    function [2:0] cycles_of;
        input [2:0] mode;
        begin
            if (mode == `MODE_WORK) begin
                cycles_of = `CYC_SHORT;
            end else begin
                cycles_of = `CYC_LONG;
            end
        end
    endfunction

    function [1:0] bytes_of;
        input three_byte;
        begin
            if (three_byte) begin
                bytes_of = `LEN_LONG;
            end else begin
                bytes_of = `LEN_SHORT;
            end
        end
    endfunction

    localparam ST_IDLE = 2'b00;
    localparam ST_EXEC = 2'b01;
    localparam ST_DONE = 2'b10;

    reg  [1:0] state;
    reg  [2:0] count;
    reg        op_carry;
    reg  [7:0] op_dst_addr;
    reg        latch_carry;
    reg  [7:0] dst_latched;
    reg  [7:0] src_latched;

    wire [2:0] mode_now  = src_mode_of(opcode);
    wire       long_now  = is_long_mode(mode_now);
    wire [7:0] adc_base  = `OPC_ADC_RR;
    wire       carry_now = (opcode[7:4] == adc_base[7:4]);
    wire [2:0] cyc_now   = cycles_of(mode_now);

    // Field split of operand bytes
    reg  [7:0] next_dst_addr;
    reg  [7:0] next_src_addr;
    reg  [7:0] next_imm;
    always @* begin
        next_dst_addr = `RST_BYTE;
        next_src_addr = `RST_BYTE;
        next_imm      = `RST_BYTE;
        case (mode_now)
            `MODE_WORK, `MODE_IND_WORK: begin
                next_dst_addr = {4'h0, operand1[7:4]};
                next_src_addr = {4'h0, operand1[3:0]};
            end
            `MODE_REG, `MODE_IND_FULL: begin
                next_src_addr = operand1;
                next_dst_addr = operand2;
            end
            `MODE_IMM: begin
                next_dst_addr = operand1;
                next_imm      = operand2;
            end
            default: begin
                next_dst_addr = `RST_BYTE;
            end
        endcase
    end

    // Arithmetic, ripple chain with carries out of bit 3 and bit 7
    wire       cin       = op_carry & latch_carry;
    wire [8:0] chain;
    wire [7:0] sum;
    assign chain[0] = cin;
    genvar b;
    generate
        for (b = 0; b < 8; b = b + 1) begin : g_bit
            assign sum[b]     = dst_latched[b] ^ src_latched[b] ^ chain[b];
            assign chain[b+1] = (dst_latched[b] & src_latched[b]) |
                                (chain[b] & (dst_latched[b] ^ src_latched[b]));
        end
    endgenerate
    wire       carry_out = chain[8];
    wire       half_out  = chain[4];
    wire       same_sign = (dst_latched[7] == src_latched[7]);
    wire       sign_flip = (sum[7] != dst_latched[7]);

    reg  [5:0] next_flags;
    always @* begin
        next_flags = `RST_FLAGS;
        next_flags[`FLG_C] = carry_out;
        next_flags[`FLG_Z] = (sum == 8'h00);
        next_flags[`FLG_S] = sum[7];
        next_flags[`FLG_V] = same_sign && sign_flip;
        next_flags[`FLG_D] = 1'b0;
        next_flags[`FLG_H] = half_out;
    end

    wire       finish = (state == ST_EXEC) && (count == 3'd1);
    wire [5:0] flags;

    add_result_stage u_stage (
        .clk         (clk),
        .rstn        (rstn),
        .load        (finish),
        .next_result (sum),
        .next_flags  (next_flags),
        .result      (result),
        .flags       (flags)
    );

    assign flag_c = flags[`FLG_C];
    assign flag_z = flags[`FLG_Z];
    assign flag_s = flags[`FLG_S];
    assign flag_v = flags[`FLG_V];
    assign flag_d = flags[`FLG_D];
    assign flag_h = flags[`FLG_H];

    // Sequencing
    wire       take   = (state == ST_IDLE) && start && is_add_op(opcode);
    wire       refuse = (state == ST_IDLE) && start && !is_add_op(opcode);

    reg  [1:0] next_state;
    reg  [2:0] next_count;
    always @* begin
        next_state = state;
        next_count = count;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = ST_EXEC;
                    next_count = cyc_now - 3'd1;
                end
            end
            ST_EXEC: begin
                next_count = count - 3'd1;
                if (finish) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            count <= 3'd0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // Decode fields held until the next accepted instruction; decode_valid and decode_illegal pulse for one cycle
    always @(posedge clk) begin
        if (!rstn) begin
            decode_valid   <= 1'b0;
            decode_illegal <= 1'b0;
            with_carry     <= 1'b0;
            src_mode       <= `MODE_WORK;
            dst_mode       <= `MODE_WORK;
            instr_bytes    <= 2'd0;
            instr_cycles   <= 3'd0;
            dst_addr       <= `RST_BYTE;
            src_addr       <= `RST_BYTE;
            imm_value      <= `RST_BYTE;
        end else begin
            decode_valid   <= take;
            decode_illegal <= refuse;
            if (take) begin
                with_carry   <= carry_now;
                src_mode     <= mode_now;
                dst_mode     <= long_now ? `MODE_REG : `MODE_WORK;
                instr_bytes  <= bytes_of(long_now);
                instr_cycles <= cyc_now;
                dst_addr     <= next_dst_addr;
                src_addr     <= next_src_addr;
                imm_value    <= next_imm;
            end
        end
    end

    // Operand capture at the take edge
    always @(posedge clk) begin
        if (!rstn) begin
            op_carry    <= 1'b0;
            op_dst_addr <= `RST_BYTE;
            latch_carry <= 1'b0;
            dst_latched <= `RST_BYTE;
            src_latched <= `RST_BYTE;
        end else if (take) begin
            op_carry    <= carry_now;
            op_dst_addr <= next_dst_addr;
            latch_carry <= carry_in;
            dst_latched <= dst_value;
            src_latched <= (mode_now == `MODE_IMM) ? operand2 : src_value;
        end
    end

    // Completion strobes done and dst_write one cycle wide; busy held from take to finish
    always @(posedge clk) begin
        if (!rstn) begin
            busy           <= 1'b0;
            done           <= 1'b0;
            dst_write      <= 1'b0;
            dst_write_addr <= `RST_BYTE;
        end else begin
            done      <= finish;
            dst_write <= finish;
            if (take) begin
                busy <= 1'b1;
            end else if (finish) begin
                busy <= 1'b0;
            end
            if (finish) begin
                dst_write_addr <= op_dst_addr;
            end
        end
    end

endmodule // byte_add_carry_unit

// >>> sim/byte_add_carry_checker.sv
`timescale 1ns/1ps
module byte_add_carry_checker (
    // Clock and reset
    input wire logic       clk, rstn,
    // Request side
    input wire logic       start, carry_in,
    input wire logic [7:0] opcode, operand2, dst_value, src_value,
    // Answer side
    input wire logic       decode_valid, decode_illegal, busy, done, dst_write, with_carry,
    input wire logic [7:0] result,
    input wire logic       flag_c, flag_z, flag_s, flag_v, flag_d, flag_h
);
    logic [7:0] d, s;
    logic       c;
    wire  [8:0] sum = d + s + (with_carry & c);
    wire  [4:0] hs  = d[3:0] + s[3:0] + (with_carry & c);
    // Operands captured at the take edge
    always @(posedge clk) begin
        if (start && !busy && !done) begin
            d <= dst_value;
            s <= (opcode[3:0] == 4'h6) ? operand2 : src_value;
            c <= carry_in;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_take(op);
        start && !busy && !done && opcode == op;
    endsequence
    property p_short; s_take(8'h02) |=> decode_valid ##3 done; endproperty
    property p_long; s_take(8'h14) |=> decode_valid ##5 done; endproperty
    property p_illegal; s_take(8'h52) |=> decode_illegal && !busy; endproperty
    property p_sum; done |-> result == sum[7:0]; endproperty
    property p_carry; done |-> flag_c == sum[8]; endproperty
    property p_zero; done |-> flag_z == (result == 8'h00); endproperty
    property p_sign; done |-> flag_s == result[7]; endproperty
    property p_ovf; done |-> flag_v == (d[7] == s[7] && result[7] != d[7]); endproperty
    property p_dec; done |-> !flag_d && dst_write; endproperty
    property p_half; done |-> flag_h == hs[4]; endproperty
    property p_together; !done |-> $stable({result, flag_c, flag_z, flag_s, flag_v, flag_h}); endproperty
    a_short: assert property (p_short) else $error("short form timing wrong");
    a_long: assert property (p_long) else $error("long form timing wrong");
    a_illegal: assert property (p_illegal) else $error("foreign opcode not refused");
    a_sum: assert property (p_sum) else $error("sum wrong");
    a_carry: assert property (p_carry) else $error("carry flag wrong");
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    a_sign: assert property (p_sign) else $error("sign flag wrong");
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
    a_dec: assert property (p_dec) else $error("decimal flag not cleared");
    a_half: assert property (p_half) else $error("half carry wrong");
    a_together: assert property (p_together) else $error("result moved without done");
endmodule // byte_add_carry_checker
bind byte_add_carry_unit byte_add_carry_checker chk (.*);

// >>> sim/regfile_model.sv
`timescale 1ns/1ps
// Register file and carry flag of the core
module regfile_model (
    // Clock
    input wire logic       clk,
    // Write side
    input wire logic       we, done, cflag,
    input wire logic [7:0] waddr, wdata
);
    logic [7:0] mem [0:255];
    logic       carry = 1'b0;
    always @(posedge clk) begin
        if (we) mem[waddr] <= wdata;
        if (done) carry <= cflag;
    end
endmodule // regfile_model

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic       clk = 1'b0, rstn = 1'b0, start = 1'b0, carry_in = 1'b0;
    logic [7:0] opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00;
    logic [7:0] dst_value = 8'h00, src_value = 8'h00;
    logic       decode_valid, decode_illegal, with_carry, busy, done, dst_write;
    logic       flag_c, flag_z, flag_s, flag_v, flag_d, flag_h;
    logic [2:0] src_mode, dst_mode, instr_cycles;
    logic [1:0] instr_bytes;
    logic [7:0] dst_addr, src_addr, imm_value, dst_write_addr, result;
    logic [7:0] av [0:4] = '{8'hff, 8'h80, 8'h7f, 8'h0f, 8'h00};
    logic [7:0] bv [0:4] = '{8'h01, 8'h80, 8'h01, 8'h01, 8'h00};
    integer     fail_count = 0, cmp_count = 0, i;
    byte_add_carry_unit DUT (.*);
    regfile_model m (.clk(clk), .we(dst_write), .done(done), .cflag(flag_c),
                     .waddr(dst_write_addr), .wdata(result));
    initial forever #25 clk = ~clk;
    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One instruction, expectations from the operand values
    task run(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2);
        logic [7:0] da, sa, dv, sv, sp;
        logic [8:0] sum;
        logic [4:0] hs;
        logic       ci;
        integer     k;
        da = o1;
        sa = 8'h00;
        if (op[2:1] == 2'b01) begin
            da = {4'h0, o1[7:4]};
            sa = {4'h0, o1[3:0]};
        end else if (op[2:1] == 2'b10) begin
            sa = o1;
            da = o2;
        end
        dv = m.mem[da];
        sp = m.mem[sa];
        sv = (op[2:1] == 2'b11) ? o2 : op[0] ? m.mem[sp] : sp;
        ci = op[4] & m.carry;
        sum = dv + sv + ci;
        hs = dv[3:0] + sv[3:0] + ci;
        @(posedge clk);
        start <= 1'b1;
        opcode <= op;
        operand1 <= o1;
        operand2 <= o2;
        dst_value <= dv;
        src_value <= sv;
        carry_in <= m.carry;
        @(posedge clk);
        start <= 1'b0;
        #1;
        check({decode_valid, busy}, 2'b11);
        check({dst_addr, src_addr}, {da, sa});
        check({with_carry, src_mode, dst_mode, instr_bytes, instr_cycles}, {op[4], op[2:0] - 3'h2,
              op[2] ? 3'h2 : 3'h0, op[2] ? 2'd3 : 2'd2, (op[2:0] == 3'h2) ? 3'd4 : 3'd6});
        check(imm_value, (op[2:1] == 2'b11) ? o2 : 8'h00);
        k = 1;
        while (done !== 1'b1 && k < 12) begin
            @(posedge clk);
            #1;
            k = k + 1;
        end
        check(k[15:0], (op[2:0] == 3'h2) ? 16'h0004 : 16'h0006);
        check(result, sum[7:0]);
        check({flag_c, flag_z, flag_s, flag_v, flag_d, flag_h}, {sum[8], sum[7:0] == 8'h00,
              sum[7], dv[7] == sv[7] && sum[7] != dv[7], 1'b0, hs[4]});
        check(dst_write_addr, da);
        check({dst_write, busy}, 2'b10);
        @(posedge clk);
        #1;
        check(m.mem[da], sum[7:0]);
        if (sa != da) check(m.mem[sa], sp);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        #1;
        check({busy, done, result, flag_c, flag_z, flag_s, flag_v, flag_d, flag_h}, 16'h0000);
        for (i = 0; i < 256; i = i + 1) m.mem[i] = i[7:0] ^ 8'ha5;
        for (i = 0; i < 10; i = i + 1) run(8'(i < 5 ? 2 + i : 13 + i), 8'(8'h21 + i), 8'h43);
        for (i = 0; i < 10; i = i + 1) begin
            m.mem[1] = av[i % 5];
            m.mem[2] = bv[i % 5];
            run(i < 5 ? 8'h04 : 8'h14, 8'h02, 8'h01);
        end
        m.mem[3] = 8'hff;
        m.mem[4] = 8'h01;
        m.mem[5] = 8'h12;
        m.mem[6] = 8'h00;
        run(8'h04, 8'h04, 8'h03);
        run(8'h14, 8'h06, 8'h05);
        check(m.mem[5], 8'h13);
        @(posedge clk);
        start <= 1'b1;
        opcode <= 8'h52;
        @(posedge clk);
        start <= 1'b0;
        #1;
        check({decode_illegal, decode_valid, busy}, 3'b100);
        print_verdict;
    end
    initial begin
        #(50 * 3000);
        fail_count = fail_count + 1;
        print_verdict;
    end
endmodule // tb_top
